// ===== hdl/uesc_cfg.svh
// constants: register indices, field positions, masks and reset values
`ifndef UESC_CFG_SVH
`define UESC_CFG_SVH
`define UESC_IDX_HUB_CA   14'h1FA7
`define UESC_IDX_FN0_CA   14'h1FDD
`define UESC_IDX_FN1_CA   14'h1FDC
`define UESC_IDX_FN2_CA   14'h1FDB
`define UESC_IDX_HUB_CSR  14'h1FA6
`define UESC_IDX_FN0_CSR  14'h1FDA
`define UESC_IDX_FN1_CSR  14'h1FD9
`define UESC_IDX_FN2_CSR  14'h1FD8
`define UESC_IDX_HUB_BC   14'h1FA5
`define UESC_IDX_FN0_BC   14'h1FCA
`define UESC_IDX_FN1_BC   14'h1FC9
`define UESC_IDX_FN2_BC   14'h1FC8
`define UESC_IDX_ISO      14'h1FA9
`define UESC_CA_DIR       7
`define UESC_CA_DEND      6
`define UESC_CA_FSTALL    5
`define UESC_CA_TXRDY     4
`define UESC_FL_HALT      3
`define UESC_FL_SETUP     2
`define UESC_FL_OUT       1
`define UESC_FL_TXC       0
`define UESC_CA_RST       4'h0
`define UESC_FL_RST       4'h0
`define UESC_BC_RST       6'h00
`define UESC_ISO_RST      4'h0
`define UESC_CA_MASK_CTRL 4'hF
`define UESC_CA_MASK_FN   4'h7
`define UESC_FL_MASK_CTRL 4'hF
`define UESC_FL_MASK_FN   4'hA
`define UESC_CRC_BYTES    6'h02
`define UESC_MAX_LEN      8
`define UESC_RESP_OKAY    2'h0
`define UESC_RESP_SLVERR  2'h2
`endif

// ===== hdl/uesc_ep.sv
// one endpoint: control bits, status flags, byte count, handshake choice
`timescale 1ns/1ps
`default_nettype none
`include "uesc_cfg.svh"

module uesc_ep #(
	parameter bit IS_CTRL = 1'h1,
	parameter int MAX_LEN = `UESC_MAX_LEN
) (
	input  wire logic          clock,      // system clock
	input  wire logic          rst_n,      // sync reset
	input  wire logic          ca_we,      // control-and-ack write
	input  wire logic          bc_we,      // byte count write
	input  wire logic [7:0]    wdata,      // write data
	input  wire logic          is_iso,     // isochronous type
	input  wire logic          ev_setup,   // setup data stored
	input  wire logic          ev_out,     // out data arrived
	input  wire logic          ev_in_ack,  // host acked in data
	input  wire logic          ev_in_sent, // in data sent
	input  wire logic          ev_stall,   // stall sent
	input  wire logic          ev_status,  // status stage done
	input  wire logic [3:0]    ev_len,     // payload bytes
	input  wire logic          tok_in,     // token is in
	output logic [7:0]         ca_rd,      // control-and-ack view
	output logic [7:0]         csr_rd,     // status view
	output logic [7:0]         bc_rd,      // byte count view
	output uesc_pkg::uesc_hs_t resp,       // answer to a token
	output logic               irq         // event pulse
);
	import uesc_pkg::*;

	localparam logic [3:0] FL_M = IS_CTRL ? `UESC_FL_MASK_CTRL : `UESC_FL_MASK_FN;
	localparam logic [3:0] CA_M = IS_CTRL ? `UESC_CA_MASK_CTRL : `UESC_CA_MASK_FN;

	if (MAX_LEN < 1 || MAX_LEN > 15)
		$error("MAX_LEN out of range");

	logic [7:4] ca_r, ca_nxt;
	logic [3:0] fl_r, fl_nxt;
	logic [5:0] bc_r, bc_nxt;
	logic [3:0] set, clr;
	logic       len_ok, stp, out_take, hw_clr_rdy;

	always_comb
	begin
		len_ok = (ev_len <= 4'(MAX_LEN));
		stp = ev_setup && len_ok && IS_CTRL;
		out_take = ev_out && len_ok && !fl_r[`UESC_FL_OUT];
		hw_clr_rdy = ca_r[`UESC_CA_TXRDY] && (ev_in_ack || (ev_in_sent && is_iso));
		set = 4'h0;
		set[`UESC_FL_HALT] = ev_stall;
		set[`UESC_FL_SETUP] = stp;
		set[`UESC_FL_OUT] = out_take;
		set[`UESC_FL_TXC] = ev_status || (ev_in_ack && ca_r[`UESC_CA_TXRDY]);
		clr = ca_we ? wdata[3:0] : 4'h0;
		fl_nxt = (set | (fl_r & ~clr)) & FL_M;
		if (stp)
			fl_nxt = set & FL_M;
		ca_nxt = ca_r;
		if (hw_clr_rdy)
			ca_nxt[`UESC_CA_TXRDY] = 1'h0;
		if (ca_we)
			ca_nxt = wdata[7:4] & CA_M;
		bc_nxt = bc_r;
		if (stp || out_take)
			bc_nxt = 6'(ev_len) + `UESC_CRC_BYTES;
		else if (bc_we)
			bc_nxt = wdata[5:0];
		// setup, out, status end, acked in with tx complete
		irq = stp || out_take || (ev_status && IS_CTRL)
			|| (hw_clr_rdy && fl_nxt[`UESC_FL_TXC]);
		if (ca_r[`UESC_CA_FSTALL])
			resp = hs_stall;
		else if (tok_in && ca_r[`UESC_CA_TXRDY])
			resp = hs_data;
		else if (tok_in && IS_CTRL && ca_r[`UESC_CA_DEND] && !ca_r[`UESC_CA_DIR])
			resp = hs_zlp1;
		else if (tok_in || fl_r[`UESC_FL_OUT])
			resp = hs_nak;
		else
			resp = hs_ack;
		ca_rd = {ca_r, 4'h0};
		csr_rd = {4'h0, fl_r};
		bc_rd = {2'h0, bc_r};
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ca_r <= `UESC_CA_RST;
			fl_r <= `UESC_FL_RST;
			bc_r <= `UESC_BC_RST;
		end
		else
		begin
			ca_r <= ca_nxt;
			fl_r <= fl_nxt;
			bc_r <= bc_nxt;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_setup_clr;
		stp && !ev_stall && !ev_status && !ev_in_ack && !ev_out |=> fl_r == 4'h4;
	endproperty
	a_setup_clr: assert property (p_setup_clr) else $error("setup did not clear others");

	property p_halt_keep;
		fl_r[3] && !(ca_we && wdata[3]) && !stp |=> fl_r[3];
	endproperty
	a_halt_keep: assert property (p_halt_keep) else $error("halt flag lost");

	property p_keep_data;
		fl_r[1] && !stp && !bc_we |=> $stable(bc_r) && fl_r[1] == !$past(clr[1]);
	endproperty
	a_keep_data: assert property (p_keep_data) else $error("held out data changed");

	property p_set_wins;
		out_take && ca_we && wdata[1] |=> fl_r[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_rdy_clr;
		ca_r[4] && ev_in_ack && !ca_we |=> !ca_r[4] ##1 ca_r[4] == $past(ca_we && wdata[4]);
	endproperty
	a_rdy_clr: assert property (p_rdy_clr) else $error("ready not cleared on ack");

	property p_dend_kept;
		IS_CTRL && ca_r[6] && ev_status && !ca_we |-> irq ##1 ca_r[6] && fl_r[0];
	endproperty
	a_dend_kept: assert property (p_dend_kept) else $error("status end wrong");
endmodule // uesc_ep
`default_nettype wire

// ===== hdl/uesc_pkg.sv
// types shared by the endpoint status block
package uesc_pkg;
	typedef enum logic [2:0] {
		hs_nak   = 3'h0,
		hs_ack   = 3'h1,
		hs_data  = 3'h3,
		hs_stall = 3'h2,
		hs_zlp1  = 3'h6
	} uesc_hs_t;
endpackage

// ===== hdl/uesc_top.sv
// top: endpoint status and handshake block with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "uesc_cfg.svh"

//----------------------------------------------------------------------------
//----------------------------------------------------------------------------

module uesc_top #(
	parameter int MAX_LEN = `UESC_MAX_LEN // largest payload in bytes
) (
	input  wire logic          clock,         // 100 MHz system clock
	input  wire logic          rst_n,         // sync reset, active low
	input  wire logic [15:0]   s_axi_awaddr,  // write address
	input  wire logic          s_axi_awvalid, // write address valid
	output logic               s_axi_awready, // write address ready
	input  wire logic [31:0]   s_axi_wdata,   // write data
	input  wire logic [3:0]    s_axi_wstrb,   // byte enables
	input  wire logic          s_axi_wvalid,  // write data valid
	output logic               s_axi_wready,  // write data ready
	output logic [1:0]         s_axi_bresp,   // write response
	output logic               s_axi_bvalid,  // write response valid
	input  wire logic          s_axi_bready,  // write response ready
	input  wire logic [15:0]   s_axi_araddr,  // read address
	input  wire logic          s_axi_arvalid, // read address valid
	output logic               s_axi_arready, // read address ready
	output logic [31:0]        s_axi_rdata,   // read data
	output logic [1:0]         s_axi_rresp,   // read response
	output logic               s_axi_rvalid,  // read data valid
	input  wire logic          s_axi_rready,  // read data ready
	input  wire logic          tok_valid,     // token pulse from sie
	input  wire logic          tok_in,        // token is in
	input  wire logic [1:0]    tok_ep,        // token endpoint
	input  wire logic [1:0]    ev_ep,         // event endpoint
	input  wire logic          ev_setup,      // setup data stored
	input  wire logic          ev_out,        // out data arrived
	input  wire logic          ev_in_ack,     // host acked in data
	input  wire logic          ev_in_sent,    // in data sent
	input  wire logic          ev_stall,      // stall sent
	input  wire logic          ev_status,     // status stage done
	input  wire logic [3:0]    ev_len,        // payload bytes
	input  wire logic          hub_chg,       // hub status changed
	input  wire logic [2:0]    port_chg,      // port 3..1 changed
	output logic               hs_valid,      // answer pulse
	output uesc_pkg::uesc_hs_t hs_code,       // answer kind
	output logic [5:0]         hs_len,        // payload of in data
	output logic [3:0]         ep_irq,        // endpoint event pulses
	output logic [7:0]         hub_bitmap     // change bitmap to host
);
	import uesc_pkg::*;

	//------------------------------------------------------------------------
	// map
	//------------------------------------------------------------------------
	localparam int NEP = 4;
	localparam logic [13:0] CA_IDX [NEP] = '{
		`UESC_IDX_HUB_CA, `UESC_IDX_FN0_CA, `UESC_IDX_FN1_CA, `UESC_IDX_FN2_CA};
	localparam logic [13:0] CSR_IDX [NEP] = '{
		`UESC_IDX_HUB_CSR, `UESC_IDX_FN0_CSR, `UESC_IDX_FN1_CSR, `UESC_IDX_FN2_CSR};
	localparam logic [13:0] BC_IDX [NEP] = '{
		`UESC_IDX_HUB_BC, `UESC_IDX_FN0_BC, `UESC_IDX_FN1_BC, `UESC_IDX_FN2_BC};

	if (MAX_LEN < 1 || MAX_LEN > 15)
		$error("MAX_LEN out of range");

	logic [NEP-1:0] ca_we;
	logic [NEP-1:0] bc_we;
	logic [7:0]     ca_rd  [NEP];
	logic [7:0]     csr_rd [NEP];
	logic [7:0]     bc_rd  [NEP];
	uesc_hs_t       resp   [NEP];
	logic [NEP-1:0] irq;

	logic           awready_r, awready_nxt;
	logic           aw_have_r, aw_have_nxt;
	logic [13:0]    aw_idx_r, aw_idx_nxt;
	logic           wready_r, wready_nxt;
	logic           w_have_r, w_have_nxt;
	logic [7:0]     w_data_r, w_data_nxt;
	logic           w_lane_r, w_lane_nxt;
	logic           bvalid_r, bvalid_nxt;
	logic [1:0]     bresp_r, bresp_nxt;
	logic           do_wr;
	logic           wr_hit;
	logic [3:0]     iso_r, iso_nxt;
	logic           arready_r, arready_nxt;
	logic           rvalid_r, rvalid_nxt;
	logic [7:0]     rdata_r, rdata_nxt;
	logic [1:0]     rresp_r, rresp_nxt;
	logic [7:0]     rd_val;
	logic           rd_hit;
	logic           hs_valid_r, hs_valid_nxt;
	uesc_hs_t       hs_code_r, hs_code_nxt;
	logic [5:0]     hs_len_r, hs_len_nxt;
	logic [3:0]     irq_r;
	logic [7:0]     bitmap_r, bitmap_nxt;

	//------------------------------------------------------------------------
	// endpoints: hub ep0, function ep0 are control; function ep1, ep2 are not
	//------------------------------------------------------------------------
	for (genvar i = 0; i < NEP; i++)
	begin : g_ep
		uesc_ep #(
			.IS_CTRL (i < 2),
			.MAX_LEN (MAX_LEN)
		) u_ep (
			.clock      (clock),
			.rst_n      (rst_n),
			.ca_we      (ca_we[i]),
			.bc_we      (bc_we[i]),
			.wdata      (w_data_r),
			.is_iso     (iso_r[i]),
			.ev_setup   (ev_setup && ev_ep == 2'(i)),
			.ev_out     (ev_out && ev_ep == 2'(i)),
			.ev_in_ack  (ev_in_ack && ev_ep == 2'(i)),
			.ev_in_sent (ev_in_sent && ev_ep == 2'(i)),
			.ev_stall   (ev_stall && ev_ep == 2'(i)),
			.ev_status  (ev_status && ev_ep == 2'(i)),
			.ev_len     (ev_len),
			.tok_in     (tok_in),
			.ca_rd      (ca_rd[i]),
			.csr_rd     (csr_rd[i]),
			.bc_rd      (bc_rd[i]),
			.resp       (resp[i]),
			.irq        (irq[i])
		);
	end

	//------------------------------------------------------------------------
	// write channel: address and data in either order, then one response
	//------------------------------------------------------------------------
	always_comb
	begin
		aw_have_nxt = aw_have_r;
		aw_idx_nxt = aw_idx_r;
		w_have_nxt = w_have_r;
		w_data_nxt = w_data_r;
		w_lane_nxt = w_lane_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		iso_nxt = iso_r;
		ca_we = 4'h0;
		bc_we = 4'h0;
		wr_hit = 1'h0;
		if (s_axi_awvalid && awready_r)
		begin
			aw_have_nxt = 1'h1;
			aw_idx_nxt = s_axi_awaddr[15:2];
		end
		if (s_axi_wvalid && wready_r)
		begin
			w_have_nxt = 1'h1;
			w_data_nxt = s_axi_wdata[7:0];
			w_lane_nxt = s_axi_wstrb[0];
		end
		do_wr = aw_have_r && w_have_r;
		for (int i = 0; i < NEP; i++)
		begin
			if (aw_idx_r == CA_IDX[i])
			begin
				wr_hit = 1'h1;
				ca_we[i] = do_wr && w_lane_r;
			end
			if (aw_idx_r == BC_IDX[i])
			begin
				wr_hit = 1'h1;
				bc_we[i] = do_wr && w_lane_r;
			end
			// status is read-only: accepted, no effect
			if (aw_idx_r == CSR_IDX[i])
				wr_hit = 1'h1;
		end
		if (aw_idx_r == `UESC_IDX_ISO)
		begin
			wr_hit = 1'h1;
			if (do_wr && w_lane_r)
				iso_nxt = w_data_r[3:0];
		end
		if (do_wr)
		begin
			aw_have_nxt = 1'h0;
			w_have_nxt = 1'h0;
			bvalid_nxt = 1'h1;
			bresp_nxt = wr_hit ? `UESC_RESP_OKAY : `UESC_RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready)
			bvalid_nxt = 1'h0;
		awready_nxt = !aw_have_nxt && !bvalid_nxt && !do_wr;
		wready_nxt = !w_have_nxt && !bvalid_nxt && !do_wr;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			awready_r <= 1'h0;
			aw_have_r <= 1'h0;
			aw_idx_r <= 14'h0000;
			wready_r <= 1'h0;
			w_have_r <= 1'h0;
			w_data_r <= 8'h00;
			w_lane_r <= 1'h0;
			bvalid_r <= 1'h0;
			bresp_r <= `UESC_RESP_OKAY;
			iso_r <= `UESC_ISO_RST;
		end
		else
		begin
			awready_r <= awready_nxt;
			aw_have_r <= aw_have_nxt;
			aw_idx_r <= aw_idx_nxt;
			wready_r <= wready_nxt;
			w_have_r <= w_have_nxt;
			w_data_r <= w_data_nxt;
			w_lane_r <= w_lane_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			iso_r <= iso_nxt;
		end
	end

	//------------------------------------------------------------------------
	// read channel: data one cycle after the address is taken
	//------------------------------------------------------------------------
	always_comb
	begin
		rd_val = 8'h00;
		rd_hit = 1'h0;
		for (int i = 0; i < NEP; i++)
		begin
			if (s_axi_araddr[15:2] == CA_IDX[i])
			begin
				rd_hit = 1'h1;
				rd_val = ca_rd[i];
			end
			if (s_axi_araddr[15:2] == CSR_IDX[i])
			begin
				rd_hit = 1'h1;
				rd_val = csr_rd[i];
			end
			if (s_axi_araddr[15:2] == BC_IDX[i])
			begin
				rd_hit = 1'h1;
				rd_val = bc_rd[i];
			end
		end
		if (s_axi_araddr[15:2] == `UESC_IDX_ISO)
		begin
			rd_hit = 1'h1;
			rd_val = {4'h0, iso_r};
		end
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && arready_r)
		begin
			rvalid_nxt = 1'h1;
			rdata_nxt = rd_val;
			rresp_nxt = rd_hit ? `UESC_RESP_OKAY : `UESC_RESP_SLVERR;
		end
		else if (rvalid_r && s_axi_rready)
			rvalid_nxt = 1'h0;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			arready_r <= 1'h0;
			rvalid_r <= 1'h0;
			rdata_r <= 8'h00;
			rresp_r <= `UESC_RESP_OKAY;
		end
		else
		begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	//------------------------------------------------------------------------
	// link side: token answer, event pulses, change bitmap
	//------------------------------------------------------------------------
	always_comb
	begin
		hs_valid_nxt = tok_valid;
		hs_code_nxt = tok_valid ? resp[tok_ep] : hs_nak;
		hs_len_nxt = 6'h00;
		// payload is count less crc
		if (hs_code_nxt == hs_data && bc_rd[tok_ep][5:0] >= `UESC_CRC_BYTES)
			hs_len_nxt = bc_rd[tok_ep][5:0] - `UESC_CRC_BYTES;
		bitmap_nxt = {4'h0, port_chg, hub_chg};
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			hs_valid_r <= 1'h0;
			hs_code_r <= hs_nak;
			hs_len_r <= 6'h00;
			irq_r <= 4'h0;
			bitmap_r <= 8'h00;
		end
		else
		begin
			hs_valid_r <= hs_valid_nxt;
			hs_code_r <= hs_code_nxt;
			hs_len_r <= hs_len_nxt;
			irq_r <= irq;
			bitmap_r <= bitmap_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = {24'h000000, rdata_r};
	assign s_axi_rresp = rresp_r;
	assign hs_valid = hs_valid_r;
	assign hs_code = hs_code_r;
	assign hs_len = hs_len_r;
	assign ep_irq = irq_r;
	assign hub_bitmap = bitmap_r;

	//------------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_bitmap;
		1'h1 |=> hub_bitmap == {4'h0, $past(port_chg), $past(hub_chg)};
	endproperty
	a_bitmap: assert property (p_bitmap) else $error("bitmap wrong");

	property p_stall;
		tok_valid && ca_rd[tok_ep][5] |=> hs_valid && hs_code == hs_stall;
	endproperty
	a_stall: assert property (p_stall) else $error("forced halt not answered");

	property p_out_nak;
		tok_valid && !tok_in && csr_rd[tok_ep][1] && !ca_rd[tok_ep][5] |=> hs_code == hs_nak;
	endproperty
	a_out_nak: assert property (p_out_nak) else $error("out not refused");

	property p_zlp;
		tok_valid && tok_in && tok_ep < 2'h2 && ca_rd[tok_ep][7:4] == 4'h4
			|=> hs_code == hs_zlp1;
	endproperty
	a_zlp: assert property (p_zlp) else $error("status in not data1");

	property p_len;
		tok_valid && resp[tok_ep] == hs_data && bc_rd[tok_ep] == 8'h0A |=> hs_len == 6'h08;
	endproperty
	a_len: assert property (p_len) else $error("payload length wrong");

	property p_fn_csr;
		s_axi_arvalid && arready_r && s_axi_araddr[15:2] == CSR_IDX[2]
			|=> (s_axi_rdata[7:0] & 8'hF5) == 8'h00;
	endproperty
	a_fn_csr: assert property (p_fn_csr) else $error("function status bits");

	property p_unmapped;
		s_axi_arvalid && arready_r && !rd_hit
			|=> s_axi_rdata == 32'h0 && s_axi_rresp == `UESC_RESP_SLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");

	property p_setup_irq;
		ev_setup && ev_ep == 2'h0 && ev_len <= 4'(MAX_LEN)
			|=> ep_irq[0] ##1 csr_rd[0][2];
	endproperty
	a_setup_irq: assert property (p_setup_irq) else $error("setup event missing");

	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");

	c_setup: cover property (ev_setup ##1 ep_irq[0]);
	c_stall: cover property (hs_valid && hs_code == hs_stall);
	c_zlp: cover property (hs_valid && hs_code == hs_zlp1);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // uesc_top
`default_nettype wire

// ===== testbench/uesc_host_model.sv
// host and serial engine model: sends tokens and endpoint events
`timescale 1ns/1ps
`default_nettype none

module uesc_host_model (
	input  wire logic       clock,      // system clock
	input  wire logic       hs_valid,   // answer pulse
	input  wire logic [2:0] hs_code,    // answer kind
	input  wire logic [5:0] hs_len,     // payload to send
	output logic            tok_valid,  // token pulse
	output logic            tok_in,     // token is in
	output logic [1:0]      tok_ep,     // token endpoint
	output logic [1:0]      ev_ep,      // event endpoint
	output logic            ev_setup,   // setup stored
	output logic            ev_out,     // out data stored
	output logic            ev_in_ack,  // host acked in data
	output logic            ev_in_sent, // in data sent
	output logic            ev_stall,   // stall sent
	output logic            ev_status,  // status stage done
	output logic [3:0]      ev_len      // payload bytes
);
	logic [5:0] pulse_r;

	assign {ev_status, ev_stall, ev_in_sent, ev_in_ack, ev_out, ev_setup} = pulse_r;

	initial
	begin
		pulse_r = 6'h00;
		tok_valid = 1'h0;
		tok_in = 1'h0;
		tok_ep = 2'h0;
		ev_ep = 2'h0;
		ev_len = 4'h0;
	end

	//------------------------------------------------------------------
	// one token, answer taken in the cycle after
	//------------------------------------------------------------------
	task automatic token(input logic in, input logic [1:0] ep, output logic [8:0] ans);
		@(posedge clock);
		tok_valid <= 1'h1;
		tok_in <= in;
		tok_ep <= ep;
		@(posedge clock);
		tok_valid <= 1'h0;
		tok_in <= ~in;
		tok_ep <= ~ep;
		#1;
		ans = (hs_valid === 1'h1) ? {hs_code, hs_len} : 9'h1FF;
	endtask

	// k: 0 setup, 1 out, 2 in ack, 3 in sent, 4 stall, 5 status
	task automatic fire(input int k, input logic [1:0] ep, input logic [3:0] len);
		@(posedge clock);
		pulse_r <= 6'h01 << k;
		ev_ep <= ep;
		ev_len <= len; // payloads kept within eight bytes
		@(posedge clock);
		pulse_r <= 6'h00;
		ev_ep <= ~ep;
		ev_len <= ~len;
	endtask
endmodule // uesc_host_model

`default_nettype wire

// ===== testbench/usb_endpoint_status_control_bench.sv
// bench: register, token and event tests of the endpoint status block
`timescale 1ns/1ps
`default_nettype none
`include "uesc_cfg.svh"

module usb_endpoint_status_control_bench;
	import uesc_pkg::*;
	logic        clock = 1'h0, rst_n = 1'h0;
	logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, ev_len, ep_irq;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, hub_chg = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, tok_ep, ev_ep, rsp;
	logic [2:0]  port_chg = 3'h0;
	logic        tok_valid, tok_in, ev_setup, ev_out, ev_in_ack, ev_in_sent, ev_stall;
	logic        ev_status, hs_valid;
	uesc_hs_t    hs_code;
	logic [5:0]  hs_len;
	logic [7:0]  hub_bitmap;
	int          fails = 0, samples_checked = 0, cycles = 0;

	uesc_top uesc_top_inst (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tok_valid, .tok_in, .tok_ep, .ev_ep,
		.ev_setup, .ev_out, .ev_in_ack, .ev_in_sent, .ev_stall, .ev_status, .ev_len,
		.hub_chg, .port_chg, .hs_valid, .hs_code, .hs_len, .ep_irq, .hub_bitmap);

	uesc_host_model uesc_host_model_inst (.clock, .hs_valid, .hs_code, .hs_len, .tok_valid,
		.tok_in, .tok_ep, .ev_ep, .ev_setup, .ev_out, .ev_in_ack, .ev_in_sent, .ev_stall,
		.ev_status, .ev_len);

	always #5 clock = ~clock;

	//------------------------------------------------------------------
	// bus tasks and comparisons
	//------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		logic a, w;
		a = 1'h0;
		w = 1'h0;
		@(posedge clock);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (!(a && w))
		begin
			@(posedge clock);
			if (s_axi_awready === 1'h1)
				a = 1'h1;
			if (s_axi_wready === 1'h1)
				w = 1'h1;
			if (a)
				s_axi_awvalid <= 1'h0;
			if (w)
				s_axi_wvalid <= 1'h0;
		end
		do @(posedge clock); while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		rsp = s_axi_bresp;
	endtask

	task automatic rc(input logic [13:0] idx, input logic [7:0] exp);
		@(posedge clock);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clock); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clock); while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		rsp = s_axi_rresp;
		chk(s_axi_rdata, {24'h0, exp});
	endtask

	task automatic tk(input logic in, input logic [1:0] ep, input logic [8:0] exp);
		logic [8:0] ans;
		uesc_host_model_inst.token(in, ep, ans);
		chk({23'h0, ans}, {23'h0, exp});
	endtask

	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			fails++;
			finish_test();
		end
	end

	//------------------------------------------------------------------
	// tests
	//------------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clock);
		rst_n <= 1'h1;
		rc(`UESC_IDX_HUB_CA, 8'h00);
		hub_chg <= 1'h1;
		port_chg <= 3'h5;
		repeat (2) @(posedge clock);
		#1 chk({24'h0, hub_bitmap}, 32'h0B);
		$display("test reset and bitmap done");
		uesc_host_model_inst.fire(4, 2'h0, 4'h0);
		uesc_host_model_inst.fire(0, 2'h0, 4'h8);
		#1 chk({28'h0, ep_irq}, 32'h1);
		rc(`UESC_IDX_HUB_CSR, 8'h04);
		rc(`UESC_IDX_HUB_BC, 8'h0A);
		wr(`UESC_IDX_HUB_CA, 8'h04);
		rc(`UESC_IDX_HUB_CSR, 8'h00);
		$display("test setup done");
		uesc_host_model_inst.fire(1, 2'h2, 4'h3);
		#1 chk({28'h0, ep_irq}, 32'h4);
		rc(`UESC_IDX_FN1_CSR, 8'h02);
		tk(1'h0, 2'h2, {hs_nak, 6'h00});
		uesc_host_model_inst.fire(1, 2'h2, 4'h6);
		#1 chk({28'h0, ep_irq}, 32'h0);
		rc(`UESC_IDX_FN1_BC, 8'h05);
		wr(`UESC_IDX_FN1_CA, 8'h02);
		rc(`UESC_IDX_FN1_CSR, 8'h00);
		tk(1'h0, 2'h2, {hs_ack, 6'h00});
		// out data lands in the cycle the ack write clears the flag
		fork
			wr(`UESC_IDX_FN1_CA, 8'h02);
			begin
				@(posedge clock);
				uesc_host_model_inst.fire(1, 2'h2, 4'h1);
			end
		join
		rc(`UESC_IDX_FN1_CSR, 8'h02);
		$display("test out done");
		wr(`UESC_IDX_FN1_CA, 8'hFF);
		rc(`UESC_IDX_FN1_CA, 8'h70);
		tk(1'h1, 2'h2, {hs_stall, 6'h00});
		uesc_host_model_inst.fire(4, 2'h2, 4'h0);
		rc(`UESC_IDX_FN1_CSR, 8'h08);
		wr(`UESC_IDX_FN1_CSR, 8'hFF);
		chk({30'h0, rsp}, 32'h0);
		rc(`UESC_IDX_FN1_CSR, 8'h08);
		wr(`UESC_IDX_FN1_CA, 8'h08);
		rc(`UESC_IDX_FN1_CSR, 8'h00);
		rc(`UESC_IDX_FN1_CA, 8'h00);
		$display("test stall done");
		wr(`UESC_IDX_FN2_CA, 8'h10);
		uesc_host_model_inst.fire(3, 2'h3, 4'h0);
		rc(`UESC_IDX_FN2_CA, 8'h10);
		wr(`UESC_IDX_ISO, 8'h08);
		uesc_host_model_inst.fire(3, 2'h3, 4'h0);
		rc(`UESC_IDX_FN2_CA, 8'h00);
		$display("test isochronous done");
		wr(`UESC_IDX_HUB_BC, 8'h0A);
		wr(`UESC_IDX_HUB_CA, 8'h10);
		tk(1'h1, 2'h0, {hs_data, 6'h08});
		uesc_host_model_inst.fire(2, 2'h0, 4'h0);
		#1 chk({28'h0, ep_irq}, 32'h1);
		rc(`UESC_IDX_HUB_CA, 8'h00);
		rc(`UESC_IDX_HUB_CSR, 8'h01);
		wr(`UESC_IDX_HUB_CA, 8'h41);
		tk(1'h1, 2'h0, {hs_zlp1, 6'h00});
		uesc_host_model_inst.fire(5, 2'h0, 4'h0);
		#1 chk({28'h0, ep_irq}, 32'h1);
		rc(`UESC_IDX_HUB_CSR, 8'h01);
		rc(`UESC_IDX_HUB_CA, 8'h40);
		wr(`UESC_IDX_HUB_CA, 8'hC0);
		tk(1'h1, 2'h0, {hs_nak, 6'h00});
		rc(14'h0000, 8'h00);
		chk({30'h0, rsp}, 32'h2);
		wr(14'h0000, 8'h55);
		chk({30'h0, rsp}, 32'h2);
		$display("test transmit done");
		finish_test();
	end
endmodule // usb_endpoint_status_control_bench

`default_nettype wire
